//--- design/sdl_device.sv
// DAC loader end: shift register, chain output and eight DAC registers
// What this block does
// - Shift serial_in on rising link clock only
// - Shift register is exactly twelve bits
// - Word is four address, eight data bits
// - Eight address codes do nothing
// - Act only on load strobe rising edge
// - Write data into addressed channel only
// - Host clocks twelve edges before loading
// - Host loads before thirteenth clock edge
// - serial_out lags serial_in twelve edges
// - Host sends zero address to idle packages; sdl_host pads nothing and sends the queued words as given
// - Host pulses load strobe after shifting, not as chip select
// - Chain of three takes thirty-six bits
// - Host clocks only when updating
// - Low preset forces half scale asynchronously
module sdl_device (
  input  wire logic                           clk,
  input  wire logic                           resetn,
  sdl_link_if.device                          link,
  output logic [sdl_pkg::DATA_BITS-1:0]       dacCode [sdl_pkg::NUM_DACS],
  output logic [sdl_pkg::NUM_DACS-1:0]        dacUpdate
);
  // ****************************************
  // Input synchronisers
  // ****************************************
  logic [2:0] sclkSync;
  logic [2:0] dataSync;
  logic [2:0] loadSync;
  logic       sclkLevel;
  logic       loadLevel;

  // Three stages; a change counts when stages two and three agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclkSync <= 3'h0;
      dataSync <= 3'h0;
      loadSync <= 3'h0;
    end else begin
      sclkSync <= {sclkSync[1:0], link.sclk};
      dataSync <= {dataSync[1:0], link.serial_in};
      loadSync <= {loadSync[1:0], link.load_strobe};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sclkLevel <= 1'b0;
      loadLevel <= 1'b0;
    end else begin
      if (sclkSync[1] == sclkSync[2])
        sclkLevel <= sclkSync[2];
      if (loadSync[1] == loadSync[2])
        loadLevel <= loadSync[2];
    end
  end

  logic sclkRise;
  logic loadRise;
  assign sclkRise = (sclkSync[1] == sclkSync[2]) && sclkSync[2] && !sclkLevel;
  assign loadRise = (loadSync[1] == loadSync[2]) && loadSync[2] && !loadLevel;

  // ****************************************
  // Shift register and chain output
  // ****************************************
  logic [sdl_pkg::WORD_BITS-1:0] shiftReg;
  logic                          serialOut;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shiftReg <= '0;
    end else if (sclkRise) begin
      // Data taken at the same stage depth as the clock: sample is stable
      shiftReg <= {shiftReg[sdl_pkg::WORD_BITS-2:0], dataSync[2]};
    end
  end

  // MSB leaves after twelve rising edges, feeding the next chained package
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      serialOut <= 1'b0;
    end else if (sclkRise) begin
      serialOut <= shiftReg[sdl_pkg::WORD_BITS-1];
    end
  end
  assign link.serial_out = serialOut;

  // ****************************************
  // Address decode and DAC registers
  // ****************************************
  logic [sdl_pkg::ADDR_BITS-1:0] wordAddr;
  logic [sdl_pkg::DATA_BITS-1:0] wordData;
  assign wordAddr = shiftReg[sdl_pkg::ADDR_MSB:sdl_pkg::ADDR_LSB];
  assign wordData = shiftReg[sdl_pkg::DATA_MSB:0];

  function automatic logic [sdl_pkg::NUM_DACS-1:0] decodeSel(
    input logic [sdl_pkg::ADDR_BITS-1:0] addr
  );
    logic [sdl_pkg::ADDR_BITS-1:0] idx;
    decodeSel = '0;
    idx = addr - sdl_pkg::ADDR_FIRST;
    // Zero and codes above eight select nothing
    if (addr >= sdl_pkg::ADDR_FIRST &&
        idx < sdl_pkg::ADDR_BITS'(sdl_pkg::NUM_DACS))
      decodeSel[idx[2:0]] = 1'b1;
  endfunction : decodeSel

  logic [sdl_pkg::NUM_DACS-1:0] selMask;
  assign selMask = loadRise ? decodeSel(wordAddr) : '0;

  // Preset is a raw async load of half scale: the analog side needs it without clk
  genvar ch;
  generate
    for (ch = 0; ch < sdl_pkg::NUM_DACS; ch++) begin : gDac
      always_ff @(posedge clk or negedge link.preset_n) begin
        if (!link.preset_n) begin
          dacCode[ch] <= sdl_pkg::HALF_SCALE;
        end else if (selMask[ch]) begin
          dacCode[ch] <= wordData;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      dacUpdate <= '0;
    else
      dacUpdate <= selMask;
  end
endmodule : sdl_device

//--- design/sdl_fifo.sv
// Word FIFO in flip-flops, valid/ready on both sides
module sdl_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic [WIDTH-1:0]      outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             doWr;
  logic             doRd;

  assign inReady  = count != (AW+1)'(DEPTH);
  assign outValid = count != '0;
  assign doWr     = inValid && inReady;
  assign doRd     = outValid && outReady;
  assign outData  = mem[rdPtr];

  always_ff @(posedge clk) begin
    if (doWr)
      mem[wrPtr] <= inData;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (doWr)
        wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
      if (doRd)
        rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
      count <= count + (AW+1)'(doWr) - (AW+1)'(doRd);
    end
  end
endmodule : sdl_fifo

//--- design/sdl_host.sv
// Host end: queues command words and drives the five-wire link
module sdl_host #(
  parameter int HALF_CYC = sdl_pkg::SCLK_HALF_CYC,
  parameter int CHAIN    = 1
) (
  input  wire logic                          clk,
  input  wire logic                          resetn,
  input  wire logic [sdl_pkg::WORD_BITS-1:0] cmdWord,
  input  wire logic                          cmdValid,
  output logic                               cmdReady,
  input  wire logic                          presetReq,
  output logic                               busy,
  sdl_link_if.host                           link
);
  localparam int BITS = sdl_pkg::WORD_BITS * CHAIN;
  localparam int BW   = $clog2(BITS + 1);
  localparam int HW   = $clog2(HALF_CYC + 1);

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_LOW   = 2'b01,
    ST_HIGH  = 2'b10,
    ST_LOAD  = 2'b11
  } sdl_state_t;

  logic [sdl_pkg::WORD_BITS-1:0] qData;
  logic                          qValid;
  logic                          qReady;

  sdl_fifo #(.WIDTH(sdl_pkg::WORD_BITS), .DEPTH(sdl_pkg::FIFO_DEPTH)) uFifo (
    .clk      (clk),
    .resetn   (resetn),
    .inData   (cmdWord),
    .inValid  (cmdValid),
    .inReady  (cmdReady),
    .outData  (qData),
    .outValid (qValid),
    .outReady (qReady)
  );

  // ****************************************
  // Link clock divider and sequencer
  // ****************************************
  sdl_state_t     state;
  logic [HW-1:0]  divCnt;
  logic           tick;
  logic [BW-1:0]  bitCnt;
  logic [BITS-1:0] txShift;
  logic [BW-1:0]  fillCnt;

  assign tick   = divCnt == HW'(HALF_CYC - 1);
  // Words for a chain are gathered before shifting starts
  assign qReady = (state == ST_IDLE) && (fillCnt != BW'(BITS));
  assign busy   = state != ST_IDLE;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
      divCnt <= '0;
    else if (state == ST_IDLE || tick)
      divCnt <= '0;
    else
      divCnt <= divCnt + 1'b1;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state   <= ST_IDLE;
      bitCnt  <= '0;
      txShift <= '0;
      fillCnt <= '0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (qValid && qReady) begin
            // First word queued is sent first, lands in farthest package
            // Shift form stays legal when the chain holds a single word
            txShift <= (txShift << sdl_pkg::WORD_BITS) | BITS'(qData);
            fillCnt <= fillCnt + BW'(sdl_pkg::WORD_BITS);
          end else if (fillCnt == BW'(BITS)) begin
            state  <= ST_LOW;
            bitCnt <= '0;
          end
        end
        ST_LOW: if (tick) begin
          state <= ST_HIGH;
        end
        ST_HIGH: if (tick) begin
          txShift <= {txShift[BITS-2:0], 1'b0};
          bitCnt  <= bitCnt + 1'b1;
          state   <= (bitCnt == BW'(BITS - 1)) ? ST_LOAD : ST_LOW;
        end
        ST_LOAD: if (tick) begin
          state   <= ST_IDLE;
          fillCnt <= '0;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Pin drivers from flops
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      link.sclk        <= 1'b0;
      link.serial_in   <= 1'b0;
      link.load_strobe <= 1'b0;
      link.preset_n    <= 1'b0;
    end else begin
      link.sclk        <= state == ST_HIGH;
      link.serial_in   <= txShift[BITS-1];
      link.load_strobe <= state == ST_LOAD;
      link.preset_n    <= !presetReq;
    end
  end
endmodule : sdl_host

//--- design/sdl_link_if.sv
// Five-wire link between the host end and the DAC loader end
interface sdl_link_if;
  logic sclk;
  logic serial_in;
  logic load_strobe;
  logic serial_out;
  logic preset_n;
  modport host (
    output sclk,
    output serial_in,
    output load_strobe,
    output preset_n,
    input  serial_out
  );
  modport device (
    input  sclk,
    input  serial_in,
    input  load_strobe,
    input  preset_n,
    output serial_out
  );
endinterface : sdl_link_if

//--- design/sdl_pkg.sv
// Shared constants for the serial DAC loader link
package sdl_pkg;
  localparam int WORD_BITS = 12;
  localparam int ADDR_BITS = 4;
  localparam int DATA_BITS = 8;
  localparam int NUM_DACS  = 8;
  localparam int ADDR_MSB  = 11;
  localparam int ADDR_LSB  = 8;
  localparam int DATA_MSB  = 7;
  localparam logic [ADDR_BITS-1:0] ADDR_NOP   = 4'h0;
  localparam logic [ADDR_BITS-1:0] ADDR_FIRST = 4'h1;
  localparam logic [DATA_BITS-1:0] HALF_SCALE = 8'h80;
  localparam int CLK_MHZ       = 20;
  localparam int SCLK_HALF_NS  = 200;
  localparam int SCLK_HALF_CYC = (SCLK_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam int FIFO_DEPTH    = 16;
endpackage : sdl_pkg

//--- tb/sdl_link_assertions.sv
// Link protocol assertions for the serial DAC loader
module sdl_link_assertions (
  input wire logic clk,
  input wire logic resetn,
  input wire logic sclk,
  input wire logic serial_in,
  input wire logic load_strobe,
  input wire logic serial_out,
  input wire logic preset_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0]  riseCnt;
  logic [3:0]  seenCnt;
  logic [12:0] hist;
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ******
  // Helpers
  // ******
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) riseCnt <= 4'h0;
    else if ($rose(load_strobe)) riseCnt <= 4'h0;
    else if ($rose(sclk)) riseCnt <= riseCnt + 4'h1;
  end
  // Saturates at thirteen: only says a full thirteen-bit history exists
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) seenCnt <= 4'h0;
    else if ($rose(sclk) && seenCnt != 4'hD) seenCnt <= seenCnt + 4'h1;
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) hist <= 13'h0;
    else if ($rose(sclk)) hist <= {hist[11:0], serial_in};
  end
  sequence strobeUp;
    $rose(load_strobe);
  endsequence
  a_load_after_twelve: assert property (strobeUp |-> riseCnt == 4'hC)
    else $error("load strobe without twelve clock edges");
  a_no_thirteenth: assert property (riseCnt <= 4'hC)
    else $error("thirteenth clock edge before load");
  a_strobe_clock_low: assert property (load_strobe |-> !sclk)
    else $error("link clock high during load");
  a_strobe_width: assert property (strobeUp |-> load_strobe[*4] ##1 !load_strobe)
    else $error("load strobe width wrong");
  a_sclk_high_width: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
    else $error("link clock high phase wrong");
  a_data_stable_high: assert property (sclk |-> $stable(serial_in))
    else $error("serial data moved while clock high");
  a_chain_delay: assert property ($rose(sclk) && seenCnt == 4'hD |-> serial_out == hist[12])
    else $error("chain output not twelve edges late");
  a_strobe_after_fall: assert property (strobeUp |-> $fell(sclk))
    else $error("load not raised as link clock fell");
endmodule : sdl_link_assertions

//--- tb/serial_dac_register_loader_bench.sv
// Self-checking bench: host end and DAC end joined on one link
module serial_dac_register_loader_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk;
  logic        resetn;
  logic [11:0] cmdWord;
  logic        cmdValid;
  logic        cmdReady;
  logic        presetReq;
  logic        busy;
  logic [7:0]  dacCode [8];
  logic [7:0]  dacUpdate;
  logic [7:0]  expCode [8];
  logic [31:0] seed;
  int          err_total;
  int          total_checks;
  int          acc;
  int          expUpd;
  int          updSeen;
  sdl_link_if link ();
  sdl_host sdl_host_i (.clk(clk), .resetn(resetn), .cmdWord(cmdWord),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .presetReq(presetReq),
    .busy(busy), .link(link.host));
  sdl_device sdl_device_i (.clk(clk), .resetn(resetn), .link(link.device),
    .dacCode(dacCode), .dacUpdate(dacUpdate));
  sdl_link_assertions sdl_link_assertions_i (.clk(clk), .resetn(resetn),
    .sclk(link.sclk), .serial_in(link.serial_in),
    .load_strobe(link.load_strobe), .serial_out(link.serial_out),
    .preset_n(link.preset_n));
  // ******
  // Helpers
  // ******
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
  endfunction : lfsr
  function automatic void model(input logic [11:0] w);
    if (w[11:8] >= 4'h1 && w[11:8] <= 4'h8) begin
      expCode[w[11:8] - 4'h1] = w[7:0];
      expUpd++;
    end
  endfunction : model
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask : check
  task automatic compare_all();
    for (int i = 0; i < 8; i++)
      check(dacCode[i] === expCode[i], "dac code");
  endtask : compare_all
  task automatic send(input logic [11:0] w);
    @(negedge clk);
    cmdWord = w;
    cmdValid = 1'b1;
    while (cmdReady !== 1'b1) @(negedge clk);
    model(w);
    @(negedge clk);
    cmdValid = 1'b0;
  endtask : send
  // Waits for twelve quiet cycles so a queued word cannot hide
  task automatic settle();
    int n;
    n = 0;
    for (int t = 0; t < 5000 && n < 12; t++) begin
      @(negedge clk);
      n = (busy === 1'b0) ? n + 1 : 0;
    end
    check(n == 12, "link never idle");
  endtask : settle
  task automatic report_and_stop();
    $display("Checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  always @(negedge clk) if (resetn === 1'b1) updSeen += $countones(dacUpdate);
  // ******
  // Sequence
  // ******
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #1000000;
    err_total++;
    report_and_stop();
  end
  initial begin
    resetn = 1'b0;
    cmdWord = 12'h000;
    cmdValid = 1'b0;
    presetReq = 1'b0;
    seed = 32'h2EE1;
    foreach (expCode[i]) expCode[i] = sdl_pkg::HALF_SCALE;
    repeat (4) @(negedge clk);
    resetn = 1'b1;
    @(negedge clk);
    compare_all();
    for (int a = 0; a < 16; a++) begin
      seed = lfsr(seed);
      send({a[3:0], seed[7:0]});
      settle();
      compare_all();
    end
    send(12'h8FF);
    send(12'h100);
    repeat (4) begin
      seed = lfsr(seed);
      send(seed[11:0]);
    end
    settle();
    compare_all();
    acc = 0;
    @(negedge clk);
    cmdValid = 1'b1;
    repeat (30) begin
      seed = lfsr(seed);
      cmdWord = seed[11:0];
      if (cmdReady === 1'b1) begin
        model(cmdWord);
        acc++;
      end
      @(negedge clk);
    end
    cmdValid = 1'b0;
    check(acc >= sdl_pkg::FIFO_DEPTH && acc < 20, "fifo refusal");
    settle();
    compare_all();
    check(updSeen == expUpd, "update pulse count");
    presetReq = 1'b1;
    repeat (4) @(negedge clk);
    foreach (expCode[i]) expCode[i] = sdl_pkg::HALF_SCALE;
    compare_all();
    presetReq = 1'b0;
    report_and_stop();
  end
endmodule : serial_dac_register_loader_bench
